// *** logic/pattern_sequencer_regs.vh ***
// Constants for the pattern display sequencer.
// Included by the sequencer and its table memory; definitions only.
`ifndef PATTERN_SEQUENCER_REGS_VH
`define PATTERN_SEQUENCER_REGS_VH

// Entry word field positions
`define ENT_DEPTH_LSB    0
`define ENT_DEPTH_MSB    3
`define ENT_START_LSB    4
`define ENT_START_MSB    6
`define ENT_CHAN_LSB     7
`define ENT_CHAN_MSB     8
`define ENT_COLOR_LSB    9
`define ENT_COLOR_MSB    11
`define ENT_TRIG_BIT     12
`define ENT_FCHG_BIT     13
`define ENT_TAIL_BIT     14
`define ENT_EXP_LSB      15
`define ENT_EXP_MSB      38
`define ENT_DARK_LSB     39
`define ENT_DARK_MSB     62
`define ENT_WIDTH        63

// Timing
`define CLK_PERIOD_PS    5000
`define BLACK_TAIL_NS    105000
`define BLACK_TAIL_CYC   ((`BLACK_TAIL_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

// Reset values
`define COLOR_OFF        3'h0

`endif

// *** logic/seq_table_mem.v ***
// Pattern entry table and display order remap table.
// Assumes a single clock; read data appear one cycle after the address.
`timescale 1ns/10ps
`default_nettype none
`include "pattern_sequencer_regs.vh"
module seq_table_mem #(
  parameter AW = 6
) (
  input  wire                   mclk_i,      // Clock
  input  wire                   ent_we_i,    // Entry write strobe
  input  wire [AW-1:0]          ent_waddr_i, // Entry write address
  input  wire [`ENT_WIDTH-1:0]  ent_wdata_i, // Entry write data
  input  wire                   map_we_i,    // Remap write strobe
  input  wire [AW-1:0]          map_waddr_i, // Remap write slot
  input  wire [AW-1:0]          map_wdata_i, // Entry index for slot
  input  wire [AW-1:0]          slot_i,      // Slot to look up
  output reg  [AW-1:0]          idx_o,       // Entry index of slot
  input  wire [AW-1:0]          ent_raddr_i, // Entry read address
  output reg  [`ENT_WIDTH-1:0]  ent_o        // Entry read data
);
  reg [`ENT_WIDTH-1:0] ent_mem [0:(1<<AW)-1];
  reg [AW-1:0]         map_mem [0:(1<<AW)-1];

  always @(posedge mclk_i) begin
    if (ent_we_i) begin
      ent_mem[ent_waddr_i] <= ent_wdata_i;
    end
    if (map_we_i) begin
      map_mem[map_waddr_i] <= map_wdata_i;
    end
    idx_o <= map_mem[slot_i];
    ent_o <= ent_mem[ent_raddr_i];
  end
endmodule
`default_nettype wire

// *** logic/pattern_sequencer.v ***
// Pattern display sequencer with trigger wait and video pattern mode.
// Host loads entries and remap slots via strobes; video arrives on pins.
// How it works
// R1 - Before a trigger-wait entry, a preceding entry with its tail bit set gets an all-black tail.
// R2 - The black tail is stored with the preceding original entry and follows remaps.
// R3 - The black tail lasts 105 us.
// R4 - Without a tail, the last bit-plane of the prior slot stays during the wait.
// R5 - Host never programs an entry shorter than 105 us.
// R6 - Host may build a reusable black plus triggered black trigger set.
// R7 - Video mode takes bit-planes from incoming RGB frames, not stored images.
// R8 - Video mode: vertical sync triggers each pass through the sequence.
// R9 - Loss of video lock blanks the output with a solid curtain.
// R10 - Lock status is reported high continuously while video is locked.
// R11 - Video entry shows depth bits of one channel from start bit, chosen colour.
// R12 - After the sequence, output stays dark for the rest of the frame.
// R13 - Video mode repeats the whole sequence each frame with new data.
// R14 - Remapped slots use every attribute of the entry they point to.
// R15 - Remap writes leave entries untouched; an entry may fill several slots.
// R16 - Frame-change entry waits for next vsync before display.
// R17 - Each entry shows exposure then dark time before advancing.
`timescale 1ns/10ps
`default_nettype none
`include "pattern_sequencer_regs.vh"
module pattern_sequencer #(
  parameter AW        = 6,
  parameter TAIL_CYC  = `BLACK_TAIL_CYC,
  parameter LOCK_CYC  = 24'h0F_FFFF
) (
  input  wire                  mclk_i,         // 200 MHz clock
  input  wire                  arst_n_i,       // Async reset, low
  input  wire                  ent_we_i,       // Sequence table load strobe
  input  wire [AW-1:0]         ent_waddr_i,    // Entry address
  input  wire [`ENT_WIDTH-1:0] ent_wdata_i,    // Entry word
  input  wire                  map_we_i,       // Display order remap strobe
  input  wire [AW-1:0]         map_waddr_i,    // Remap slot
  input  wire [AW-1:0]         map_wdata_i,    // Entry for slot
  input  wire [AW-1:0]         last_slot_i,    // Last slot of sequence
  input  wire                  start_i,        // Run level
  input  wire                  video_mode_i,   // Video pattern mode
  input  wire                  trig_in_i,      // Input trigger pin
  input  wire                  vsync_i,        // Video vertical sync pin
  input  wire                  vid_de_i,       // Video data enable pin
  input  wire [23:0]           vid_rgb_i,      // Video pixel R,G,B pin
  input  wire                  stored_plane_i, // Stored image bit-plane
  output reg                   plane_o,        // Displayed bit-plane
  output reg  [2:0]            color_o,        // Illumination colour
  output reg                   curtain_o,      // Solid curtain shown
  output reg                   video_input_lock_status_o, // Locked status
  output reg                   busy_o          // Sequence running
);
  localparam S_IDLE = 7'h01, S_FETCH = 7'h02, S_WAIT = 7'h04, S_EXP = 7'h08,
             S_DARK = 7'h10, S_TAIL = 7'h20, S_FRAME = 7'h40;

  // Two-flop synchronisers
  reg [1:0]  trig_sync_reg, vs_sync_reg, de_sync_reg;
  reg [23:0] rgb_s1_reg, rgb_s2_reg;
  reg        vs_d_reg, trig_d_reg;
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      trig_sync_reg <= 2'h0;
      vs_sync_reg   <= 2'h0;
      de_sync_reg   <= 2'h0;
      rgb_s1_reg    <= 24'h0;
      rgb_s2_reg    <= 24'h0;
      vs_d_reg      <= 1'b0;
      trig_d_reg    <= 1'b0;
    end else begin
      trig_sync_reg <= {trig_sync_reg[0], trig_in_i};
      vs_sync_reg   <= {vs_sync_reg[0], vsync_i};
      de_sync_reg   <= {de_sync_reg[0], vid_de_i};
      rgb_s1_reg    <= vid_rgb_i;
      rgb_s2_reg    <= rgb_s1_reg;
      vs_d_reg      <= vs_sync_reg[1];
      trig_d_reg    <= trig_sync_reg[1];
    end
  end
  wire vs_rise   = vs_sync_reg[1] & ~vs_d_reg;
  wire trig_rise = trig_sync_reg[1] & ~trig_d_reg;

  // Lock detect: vsync must keep arriving within LOCK_CYC
  // Counter starts saturated, so two close vsyncs are needed to lock
  reg [23:0] lock_cnt_reg;
  reg        locked_reg;
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lock_cnt_reg <= LOCK_CYC[23:0];
      locked_reg   <= 1'b0;
    end else if (vs_rise) begin
      lock_cnt_reg <= 24'h0;
      locked_reg   <= (lock_cnt_reg != LOCK_CYC[23:0]); // see R10
    end else if (lock_cnt_reg == LOCK_CYC[23:0]) begin
      locked_reg   <= 1'b0;                    // see R9
    end else begin
      lock_cnt_reg <= lock_cnt_reg + 24'h1;
    end
  end

  // Frame capture: first active pixel of each frame
  reg [23:0] frame_reg;
  reg        grabbed_reg;
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      frame_reg   <= 24'h0;
      grabbed_reg <= 1'b0;
    end else if (vs_rise) begin
      grabbed_reg <= 1'b0;
    end else if (de_sync_reg[1] && !grabbed_reg) begin
      frame_reg   <= rgb_s2_reg; // see R7 R13
      grabbed_reg <= 1'b1;
    end
  end

  // Table memories
  reg  [AW-1:0]         slot_reg;
  wire [AW-1:0]         idx;
  wire [`ENT_WIDTH-1:0] ent;
  seq_table_mem #(.AW(AW)) u_mem (
    .mclk_i      (mclk_i),
    .ent_we_i    (ent_we_i),
    .ent_waddr_i (ent_waddr_i),
    .ent_wdata_i (ent_wdata_i),
    .map_we_i    (map_we_i),    // see R15
    .map_waddr_i (map_waddr_i),
    .map_wdata_i (map_wdata_i),
    .slot_i      (slot_reg),
    .idx_o       (idx),
    .ent_raddr_i (idx),         // see R14
    .ent_o       (ent)
  );

  function [7:0] pick_bits;
    input [23:0] rgb;
    input [1:0]  chan;
    begin
      case (chan)
        2'h0:    pick_bits = rgb[23:16];
        2'h1:    pick_bits = rgb[15:8];
        default: pick_bits = rgb[7:0];
      endcase
    end
  endfunction

  reg [6:0]            state_reg;
  reg [`ENT_WIDTH-1:0] cur_reg;
  reg [23:0]           tmr_reg;
  reg [3:0]            bit_reg;
  reg [1:0]            fetch_reg;
  reg                  hold_plane_reg;
  wire [3:0]  depth  = cur_reg[`ENT_DEPTH_MSB:`ENT_DEPTH_LSB];
  wire [23:0] exp_t  = cur_reg[`ENT_EXP_MSB:`ENT_EXP_LSB];
  wire [23:0] dark_t = cur_reg[`ENT_DARK_MSB:`ENT_DARK_LSB];
  wire [23:0] plane_t = (depth == 4'h0) ? exp_t : exp_t / {20'h0, depth};
  wire [2:0]  bitpos = cur_reg[`ENT_START_MSB:`ENT_START_LSB] + bit_reg[2:0];
  wire [7:0]  chanv  = pick_bits(frame_reg, cur_reg[`ENT_CHAN_MSB:`ENT_CHAN_LSB]);
  wire        live_plane = video_mode_i ? chanv[bitpos] : stored_plane_i;
  wire        at_end = (slot_reg == last_slot_i);
  wire        nxt_wait = ent[`ENT_TRIG_BIT] | ent[`ENT_FCHG_BIT] |
                         (video_mode_i & (slot_reg == {AW{1'b0}}));

  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= S_IDLE;
      cur_reg   <= {`ENT_WIDTH{1'b0}};
      slot_reg  <= {AW{1'b0}};
      tmr_reg   <= 24'h0;
      bit_reg   <= 4'h0;
      fetch_reg <= 2'h0;
      hold_plane_reg <= 1'b0;
      plane_o   <= 1'b0;
      color_o   <= `COLOR_OFF;
      curtain_o <= 1'b0;
      busy_o    <= 1'b0;
      video_input_lock_status_o <= 1'b0;
    end else begin
      video_input_lock_status_o <= locked_reg;
      curtain_o <= video_mode_i & ~locked_reg;                  // see R9
      busy_o    <= (state_reg != S_IDLE);
      case (state_reg)
        S_IDLE: begin
          plane_o  <= 1'b0;
          color_o  <= `COLOR_OFF;
          slot_reg <= {AW{1'b0}};
          if (start_i) begin
            fetch_reg <= 2'h0;
            state_reg <= S_FETCH;
          end
        end
        S_FETCH: begin
          fetch_reg <= fetch_reg + 2'h1;
          if (fetch_reg == 2'h2) begin
            cur_reg <= ent;                                      // see R14
            bit_reg <= 4'h0;
            if (nxt_wait) begin
              state_reg <= ent[`ENT_TRIG_BIT] & ~video_mode_i ? S_WAIT : S_FRAME;
            end else begin
              tmr_reg   <= 24'h0;
              state_reg <= S_EXP;
            end
          end
        end
        S_WAIT: begin
          plane_o <= hold_plane_reg;                             // see R4
          if (!start_i) begin
            state_reg <= S_IDLE;
          end else if (trig_rise) begin
            tmr_reg   <= 24'h0;
            state_reg <= S_EXP;
          end
        end
        S_FRAME: begin
          plane_o <= 1'b0;                                       // see R12
          color_o <= `COLOR_OFF;
          if (!start_i) begin
            state_reg <= S_IDLE;
          end else if (de_sync_reg[1] && !grabbed_reg) begin     // see R8 R16
            // Leave as the new frame's pixel is captured, never on stale data
            tmr_reg   <= 24'h0;
            state_reg <= S_EXP;
          end
        end
        S_EXP: begin
          plane_o <= live_plane & ~curtain_o;                    // see R11
          hold_plane_reg <= live_plane;
          color_o <= cur_reg[`ENT_COLOR_MSB:`ENT_COLOR_LSB];
          if (tmr_reg + 24'h1 >= plane_t && bit_reg + 4'h1 < depth) begin
            tmr_reg <= 24'h0;
            bit_reg <= bit_reg + 4'h1;
          end else if (tmr_reg + 24'h1 >= plane_t) begin
            tmr_reg   <= 24'h0;
            state_reg <= S_DARK;                                 // see R17
          end else begin
            tmr_reg <= tmr_reg + 24'h1;
          end
        end
        S_DARK: begin
          plane_o <= 1'b0;
          color_o <= `COLOR_OFF;                                 // see R17
          if (tmr_reg >= dark_t) begin
            tmr_reg <= 24'h0;
            if (cur_reg[`ENT_TAIL_BIT]) begin
              state_reg <= S_TAIL;                               // see R1 R2
            end else begin
              slot_reg  <= at_end ? {AW{1'b0}} : slot_reg + {{(AW-1){1'b0}}, 1'b1};
              fetch_reg <= 2'h0;
              state_reg <= (at_end & ~video_mode_i & ~start_i) ? S_IDLE : S_FETCH;
            end
          end else begin
            tmr_reg <= tmr_reg + 24'h1;
          end
        end
        S_TAIL: begin
          plane_o <= 1'b0;
          color_o <= `COLOR_OFF;                                 // see R1
          hold_plane_reg <= 1'b0;
          if (tmr_reg + 24'h1 >= TAIL_CYC[23:0]) begin          // see R3
            slot_reg  <= at_end ? {AW{1'b0}} : slot_reg + {{(AW-1){1'b0}}, 1'b1};
            fetch_reg <= 2'h0;
            state_reg <= S_FETCH;
          end else begin
            tmr_reg <= tmr_reg + 24'h1;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** testbench/pattern_sequencer_properties.sv ***
// Checker for the pattern sequencer port behaviour.
// Bound to pattern_sequencer; sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module pattern_sequencer_properties #(parameter LOCK_CYC = 24'h0F_FFFF) (
  input wire logic       mclk_i,                    // Clock
  input wire logic       arst_n_i,                  // Reset
  input wire logic       start_i,                   // Run
  input wire logic       video_mode_i,              // Video mode
  input wire logic       vsync_i,                   // Vsync pin
  input wire logic       plane_o,                   // Plane
  input wire logic [2:0] color_o,                   // Colour
  input wire logic       curtain_o,                 // Curtain
  input wire logic       video_input_lock_status_o, // Lock
  input wire logic       busy_o                     // Busy
);
  logic [23:0] quiet_reg;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  // Cycles since the last vsync pin pulse
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) quiet_reg <= 24'h0;
    else if (vsync_i) quiet_reg <= 24'h0;
    else if (quiet_reg != 24'hFFFFFF) quiet_reg <= quiet_reg + 24'h1;
  end
  a_reset_quiet: assert property ($rose(arst_n_i) |-> !busy_o && color_o == 3'h0 && !plane_o
    && !curtain_o && !video_input_lock_status_o) else $error("outputs not clear after reset");
  a_lock_timeout: assert property (quiet_reg > LOCK_CYC + 8 |-> !video_input_lock_status_o)
    else $error("lock held without vsync");
  a_curtain_on_loss: assert property ((video_mode_i [*4]) ##0 (quiet_reg > LOCK_CYC + 8)
    |-> curtain_o) else $error("no curtain after loss of lock");
  a_locked_no_curtain: assert property (video_input_lock_status_o [*2] |-> !curtain_o)
    else $error("curtain while locked");
  a_curtain_mode_only: assert property (curtain_o |-> video_mode_i || $past(video_mode_i))
    else $error("curtain outside video mode");
  a_busy_from_start: assert property ($rose(busy_o) |-> $past(start_i) || $past(start_i, 2))
    else $error("run began without start");
  a_fetch_dark: assert property ($rose(busy_o) |-> color_o == 3'h0 [*3])
    else $error("colour shown during fetch");
  a_color_when_busy: assert property (color_o != 3'h0 |-> busy_o)
    else $error("colour while idle");
endmodule
bind pattern_sequencer pattern_sequencer_properties #(.LOCK_CYC(LOCK_CYC)) u_props (
  .mclk_i(mclk_i), .arst_n_i(arst_n_i), .start_i(start_i), .video_mode_i(video_mode_i),
  .vsync_i(vsync_i), .plane_o(plane_o), .color_o(color_o), .curtain_o(curtain_o),
  .video_input_lock_status_o(video_input_lock_status_o), .busy_o(busy_o));
`default_nettype wire

// *** testbench/video_source_model.sv ***
// Video source: one-cycle vsync, one enabled pixel per frame.
// Runs on the bench clock; pixel bus toggles outside the enable.
`timescale 1ns/10ps
`default_nettype none
module video_source_model #(parameter PERIOD = 300) (
  input  wire logic        clk_i,   // Clock
  input  wire logic        run_i,   // Frames on
  output logic             vsync_o, // Vertical sync
  output logic             de_o,    // Data enable
  output logic [23:0]      rgb_o,   // Pixel bus
  output logic [23:0]      pix_o    // Frame pixel
);
  int cnt = 0;
  initial begin
    vsync_o = 0; de_o = 0; rgb_o = 24'h0; pix_o = 24'h0;
  end
  always @(posedge clk_i) begin
    #1;
    cnt = run_i ? (cnt + 1) % PERIOD : 1;
    vsync_o = run_i && cnt == 0;
    if (vsync_o) pix_o = $urandom;
    de_o = run_i && cnt == 1;
    rgb_o = de_o ? pix_o : ~rgb_o;
  end
endmodule
`default_nettype wire

// *** testbench/pattern_sequencer_bench.sv ***
// Self-checking bench for the pattern sequencer.
// Host side driven by tasks; video from the source model.
`timescale 1ns/10ps
`default_nettype none
`include "pattern_sequencer_regs.vh"
module pattern_sequencer_bench;
  logic clk = 0, rst_n = 0, we = 0, mwe = 0, start = 0, vmode = 0, trig = 0, sp = 0, hi = 0;
  logic vrun = 0, vs, de, plane, curt, lock, busy;
  logic [5:0] wa = 0, ma = 0, md = 0, last = 0;
  logic [62:0] wd = 0;
  logic [23:0] rgb, pix;
  logic [2:0] col, c0, c1, c, rc[8];
  int fail_count = 0, comparisons = 0, rl[8], nr, e0, e1, d, ch, st;
  always #2.5 clk = ~clk;
  always @(posedge clk) #1 sp = hi | $urandom;
  video_source_model u_src (.clk_i(clk), .run_i(vrun), .vsync_o(vs), .de_o(de), .rgb_o(rgb),
    .pix_o(pix));
  pattern_sequencer #(.TAIL_CYC(20), .LOCK_CYC(400)) u_dut (.mclk_i(clk), .arst_n_i(rst_n),
    .ent_we_i(we), .ent_waddr_i(wa), .ent_wdata_i(wd), .map_we_i(mwe), .map_waddr_i(ma),
    .map_wdata_i(md), .last_slot_i(last), .start_i(start), .video_mode_i(vmode),
    .trig_in_i(trig), .vsync_i(vs), .vid_de_i(de), .vid_rgb_i(rgb), .stored_plane_i(sp),
    .plane_o(plane), .color_o(col), .curtain_o(curt), .video_input_lock_status_o(lock),
    .busy_o(busy));
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Entry word: flg is {tail, frame change, trigger}
  function automatic logic [62:0] ent(int dp, s, chn, cl, flg, e, dk);
    return {dk[23:0], e[23:0], flg[2:0], cl[2:0], chn[1:0], s[2:0], dp[3:0]};
  endfunction
  task automatic wr(int a, logic [62:0] w);
    we = 1; wa = a[5:0]; wd = w; tick(); we = 0; tick();
  endtask
  task automatic map(int s, int a);
    mwe = 1; ma = s[5:0]; md = a[5:0]; tick(); mwe = 0; tick();
  endtask
  task automatic grab();
    nr = 0; rl = '{default: 0};
    for (int k = 0; k < 3000 && busy !== 1'b0; k++) begin
      tick();
      if (col !== 3'h0) begin rc[nr] = col; rl[nr]++; end
      else if (rl[nr] != 0 && nr < 7) nr++;
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    complete_run();
  end
  initial begin
    void'($urandom(32'h31C4556B));
    tick(6); rst_n = 1; tick();
    c0 = 1 + $urandom % 3; c1 = c0 + 3'h4;
    e0 = 20 + $urandom % 40; e1 = 20 + $urandom % 40;
    wr(0, ent(1, 0, 0, c0, 0, e0, $urandom % 8));
    wr(1, ent(1, 0, 0, c1, 0, e1, $urandom % 8));
    map(0, 1); map(1, 0); map(2, 1); last = 2;
    start = 1; tick(2); start = 0;
    grab();
    chk(nr, 3);
    for (int i = 0; i < 3; i++)
      chk({rc[i], rl[i][15:0]}, i == 1 ? {c0, e0[15:0]} : {c1, e1[15:0]});
    $display("test remap done");
    hi = 1; last = 1;
    for (int tl = 0; tl < 2; tl++) begin
      wr(2, ent(1, 0, 0, c0, tl * 4, 30, 0));
      wr(3, ent(1, 0, 0, c1, 1, 30, 0));
      map(0, 2); map(1, 3);
      start = 1; tick(150);
      chk(plane, tl ? 0 : 1);
      chk(col == c1, 0);
      trig = 1; tick(4); trig = 0;
      for (int k = 0; k < 200 && col !== c1; k++) tick();
      chk(col, c1);
      start = 0;
      for (int k = 0; k < 300 && busy !== 1'b0; k++) tick();
      chk(busy, 0);
    end
    $display("test trigger done");
    vmode = 1; vrun = 1; last = 0;
    tick(900);
    chk(lock, 1);
    chk(curt, 0);
    for (int f = 0; f < 3; f++) begin
      d = 1 + $urandom % 4; ch = $urandom % 3; st = $urandom % 8; c = 1 + $urandom % 7;
      wr(0, ent(d, st, ch, c, 2, 48, 0));
      map(0, 0);
      start = 1;
      for (int k = 0; k < 700 && col !== c; k++) tick();
      chk(col, c);
      for (int j = 0; j < d; j++) begin
        tick(j == 0 ? 24 / d : 48 / d);
        chk(plane, pix[(2 - ch) * 8 + (st + j) % 8]);
      end
      for (int k = 0; k < 100 && col !== 3'h0; k++) tick();
      tick(100);
      chk({col, plane}, 0);
      start = 0;
      for (int k = 0; k < 20 && busy !== 1'b0; k++) tick();
      chk(busy, 0);
    end
    start = 0; vrun = 0;
    tick(450);
    chk({lock, curt}, 1);
    $display("test video done");
    complete_run();
  end
endmodule
`default_nettype wire
